// ==== bench/dpl_far_end.sv ====
// far-end model: loop control and the phase/period error source
// assumes the caller sends at most one sample per clock on sys_clk_i
`timescale 1ns/100ps
module dpl_far_end
    import dpl_pkg::*;
(
    input  wire logic   sys_clk_i,
    output dpl_mode_t   mode_o,
    output logic [1:0]  vld_o,
    output logic [31:0] err_o
);
    // start closed and quiet
    initial begin
        mode_o = DPL_CLOSED;
        vld_o  = 2'h0;
        err_o  = 32'h0;
    end
    // one sample per edge, so back-to-back calls stream samples
    task send(input int k, input logic [31:0] e);
        @(posedge sys_clk_i);
        vld_o <= 2'h1 << k;
        err_o <= e;
    endtask
    // mode changes land on a rising edge, like every other input
    task set_mode(input dpl_mode_t m);
        @(posedge sys_clk_i);
        mode_o <= m;
    endtask
    // idle lines invert so a stale sample never looks current
    task idle();
        @(posedge sys_clk_i);
        vld_o <= 2'h0;
        err_o <= ~err_o;
    endtask
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for dpl_core with the far-end model
// assumes one 100 MHz clock and the register map of dpl_pkg
`timescale 1ns/100ps
module testbench
    import dpl_pkg::*;
;
    logic        clk, rst, wr, rd, ph_lock, fr_lock, irq;
    logic [11:0] addr;
    logic [15:0] wd, rdata, pw, p0, w, wp, fsv, ex;
    logic [9:0]  fs_o;
    logic [1:0]  vld;
    logic [31:0] err;
    logic [31:0] th[2];
    dpl_mode_t   mode;
    int          bad_count, checks_done;
    logic [11:0] ra[6] = '{12'h213, 12'h30D, 12'h330, 12'h331, 12'h332, 12'h3FF};
    dpl_mode_t   md[3] = '{DPL_SWITCH, DPL_FREE_RUN, DPL_HOLDOVER};
    logic [15:0] st[2] = '{16'hA001, 16'hFFFF};

    dpl_far_end u_far (.sys_clk_i(clk), .mode_o(mode), .vld_o(vld), .err_o(err));
    dpl_core u_dut (.sys_clk_i(clk), .reset_i(rst), .addr_i(addr), .wdata_i(wd),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .mode_i(mode),
        .phase_err_vld_i(vld[0]), .phase_err_i(err), .period_dev_vld_i(vld[1]),
        .period_dev_i(err), .phase_lock_o(ph_lock), .freq_lock_o(fr_lock),
        .phase_word_o(pw), .full_scale_current_o(fs_o), .irq_o(irq));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    always #5 clk = ~clk;
    task chk(input logic [47:0] g, input logic [47:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e);
        end
    endtask
    // one strobe cycle; read data is looked at in the cycle after it
    task bus(input logic w_en, input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        wr   <= w_en;
        rd   <= !w_en;
        addr <= a;
        wd   <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask
    task rdc(input logic [11:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk(rdata, e);
    endtask
    // fill samples sit at or under the threshold, drain ones above it
    function logic [31:0] smp(input logic [31:0] t, input bit f, input int i);
        logic [31:0] m;
        m = f ? ((i == 0) ? t : $urandom % (t + 1)) : t + 1 + $urandom % 32'h100;
        return ($urandom % 2) ? m : -m;
    endfunction
    task feed(input int k, input int n, input bit f);
        for (int i = 0; i < n; i++)
            u_far.send(k, smp(th[k], f, i));
        u_far.idle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    // top slice after n cycles of step s, with the offset moved from po to o
    function logic [15:0] pw_exp(input logic [15:0] p, s, o, po, input int n);
        return p + 16'(n) * s + o - po;
    endfunction
    task end_sim();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence; a fill of 255 needs 13 samples to cross +1024
    // ------------------------------------------------------------
    initial begin
        {clk, wr, rd, addr, wd, wp, bad_count, checks_done} = '0;
        rst = 1'b1;
        void'($urandom(32'h81DFCA2C));
        th[0] = 32'h100 | ($urandom & 32'hFF);
        th[1] = 32'h10000;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (ra[i]) rdc(ra[i], 16'h0000);
        chk({ph_lock, fr_lock, irq}, 3'h0);
        fsv = 16'($urandom) & 16'h03FF;
        bus(1'b1, OFS_FULL_SCALE, fsv);
        rdc(OFS_FULL_SCALE, fsv);
        chk(fs_o, fsv);
        bus(1'b1, 12'h3FF, 16'hFFFF);
        rdc(12'h3FF, 16'h0000);
        bus(1'b1, OFS_IRQ_MASK, 16'h0001);
        bus(1'b1, OFS_PH_THRESH, th[0][15:0]);
        bus(1'b1, OFS_PH_BUCKET, 16'hFFFF);
        bus(1'b1, OFS_FR_THR_HI, 16'h0001);
        bus(1'b1, OFS_FR_BUCKET, 16'hFFFF);
        feed(0, 12, 1'b1);
        chk({ph_lock, irq}, 2'h0);
        feed(0, 1, 1'b1);
        chk({ph_lock, irq}, 2'h3);
        bus(1'b1, OFS_IRQ_STATUS, 16'h0001);
        @(posedge clk);
        #1;
        chk(irq, 1'b0);
        // only a saturated level unlocks after exactly 13 drains
        feed(0, 20, 1'b1);
        feed(0, 12, 1'b0);
        chk(ph_lock, 1'b1);
        feed(0, 1, 1'b0);
        chk({ph_lock, irq}, 2'h0);
        foreach (md[i]) begin
            u_far.set_mode(DPL_CLOSED);
            feed(0, 13, 1'b1);
            u_far.set_mode(md[i]);
            feed(0, 20, 1'b0);
            chk(ph_lock, md[i] == DPL_SWITCH);
        end
        u_far.set_mode(DPL_CLOSED);
        feed(1, 13, 1'b1);
        chk(fr_lock, 1'b1);
        // free-run words step the top slice by the FTW2 word; 16'hFFFF wraps it on every cycle
        u_far.set_mode(DPL_FREE_RUN);
        foreach (st[i]) begin
            bus(1'b1, OFS_FREE_FTW2, st[i]);
            repeat (4) @(posedge clk);
            #1;
            p0 = pw;
            w  = 16'($urandom);
            bus(1'b1, OFS_PHASE_OFS, w);
            repeat (3) @(posedge clk);
            #1;
            ex = pw_exp(p0, st[i], w, wp, 5);
            chk(pw, ex);
            wp = w;
        end
        // coefficient exponent words and the upper frequency threshold read back masked; fraction words read back whole
        for (int k = 0; k < 8; k++) begin
            w = 16'($urandom);
            bus(1'b1, OFS_COEF_BASE + 12'(k), w);
            rdc(OFS_COEF_BASE + 12'(k), w & ((k % 2) ? 16'h07FF : 16'hFFFF));
        end
        w = 16'($urandom);
        bus(1'b1, OFS_FR_THR_HI, w);
        rdc(OFS_FR_THR_HI, w & 16'h00FF);
        end_sim();
    end

    // watchdog far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
endmodule

// ==== hw/dpl_core.sv ====
// dpll back end: loop filter, phase and frequency lock detectors, synthesizer
// accumulator with phase offset, full-scale current word and register port.
// assumes error samples and loop mode come from logic on sys_clk_i.
`timescale 1ns/100ps

module dpl_core
    import dpl_pkg::*;
(
    input  wire logic                sys_clk_i,
    input  wire logic                reset_i,
    input  wire logic [ADDR_W-1:0]   addr_i,
    input  wire logic [DATA_W-1:0]   wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic      [DATA_W-1:0]   rdata_o,
    input  wire dpl_mode_t           mode_i,
    input  wire logic                phase_err_vld_i,
    input  wire logic [ERR_W-1:0]    phase_err_i,
    input  wire logic                period_dev_vld_i,
    input  wire logic [ERR_W-1:0]    period_dev_i,
    output logic                     phase_lock_o,
    output logic                     freq_lock_o,
    output logic [15:0]              phase_word_o,
    output logic [9:0]               full_scale_current_o,
    output logic                     irq_o
);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [15:0]     fsc_q;
    logic [15:0]     phase_ofs_q;
    logic [ACC_W-1:0] free_ftw_q;
    dpl_coef_t       coef_q [4];     // alpha, beta, gamma, delta
    dpl_det_cfg_t    det_cfg_q [NUM_DET];
    logic [3:0]      irq_mask_q;
    logic [3:0]      irq_stat_q;
    logic [3:0]      irq_evt;

    // software writes; one register per address, apart from the irq status write-one-to-clear below
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            fsc_q       <= RST_REG;
            phase_ofs_q <= RST_REG;
            free_ftw_q  <= '0;
            irq_mask_q  <= '0;
            for (int k = 0; k < 4; k++) begin
                coef_q[k] <= '0;
            end
            for (int k = 0; k < NUM_DET; k++) begin
                det_cfg_q[k] <= '0;
            end
        end else if (wr_i) begin
            case (addr_i)
                OFS_FULL_SCALE: fsc_q       <= wdata_i;
                OFS_PHASE_OFS:  phase_ofs_q <= wdata_i;
                OFS_FREE_FTW0:  free_ftw_q[15:0]  <= wdata_i;
                OFS_FREE_FTW1:  free_ftw_q[31:16] <= wdata_i;
                OFS_FREE_FTW2:  free_ftw_q[47:32] <= wdata_i;
                OFS_PH_THRESH:  det_cfg_q[0].thresh <= {8'h00, wdata_i};
                OFS_PH_BUCKET: begin
                    det_cfg_q[0].fill  <= wdata_i[7:0];
                    det_cfg_q[0].drain <= wdata_i[15:8];
                end
                OFS_FR_THR_LO:  det_cfg_q[1].thresh[15:0]  <= wdata_i;
                OFS_FR_THR_HI:  det_cfg_q[1].thresh[23:16] <= wdata_i[7:0];
                OFS_FR_BUCKET: begin
                    det_cfg_q[1].fill  <= wdata_i[7:0];
                    det_cfg_q[1].drain <= wdata_i[15:8];
                end
                OFS_IRQ_MASK:   irq_mask_q <= wdata_i[3:0];
                default: begin
                    for (int k = 0; k < 4; k++) begin
                        if (addr_i == OFS_COEF_BASE + 12'(2 * k)) begin
                            coef_q[k].frac <= wdata_i;
                        end
                        if (addr_i == OFS_COEF_BASE + 12'(2 * k + 1)) begin
                            coef_q[k].neg_exp <= wdata_i[4:0];
                            coef_q[k].pos_a   <= wdata_i[7:5];
                            coef_q[k].pos_b   <= wdata_i[10:8];
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // loop filter
    // ------------------------------------------------------------
    // scale a value by fraction, negative exponent and, for alpha, two
    // positive exponents; 64-bit product keeps the wide alpha range
    function automatic logic signed [ACC_W-1:0] coef_mul(
        input logic signed [ACC_W-1:0] v,
        input dpl_coef_t               c,
        input logic                    use_pos
    );
        logic signed [63:0] p;
        p = $signed({{16{v[ACC_W-1]}}, v}) * $signed({48'h0, c.frac});
        p = p >>> (FRAC_BITS + int'(c.neg_exp));
        if (use_pos) begin
            p = p <<< (int'(c.pos_a) + int'(c.pos_b));
        end
        return p[ACC_W-1:0];
    endfunction

    logic signed [ACC_W-1:0] err48;
    logic signed [ACC_W-1:0] prop;
    logic signed [ACC_W-1:0] integ_q;
    logic signed [ACC_W-1:0] lp1_q;
    logic signed [ACC_W-1:0] lp2_q;
    logic signed [ACC_W-1:0] stage_u;

    // proportional plus integral, then two smoothing poles
    always_comb begin
        err48   = $signed({{16{phase_err_i[ERR_W-1]}}, phase_err_i});
        prop    = coef_mul(err48, coef_q[0], 1'b1);
        stage_u = prop + integ_q;
    end

    // state cleared in free-run so a new lock starts from the stored word;
    // holdover and switchover freeze it
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || mode_i == DPL_FREE_RUN) begin
            integ_q <= '0;
            lp1_q   <= '0;
            lp2_q   <= '0;
        end else if (mode_i == DPL_CLOSED && phase_err_vld_i) begin
            integ_q <= integ_q + coef_mul(err48, coef_q[1], 1'b0);
            lp1_q   <= lp1_q + coef_mul(stage_u - lp1_q, coef_q[2], 1'b0);
            lp2_q   <= lp2_q + coef_mul(lp1_q - lp2_q, coef_q[3], 1'b0);
        end
    end

    // ------------------------------------------------------------
    // tuning word selection and synthesizer accumulator
    // ------------------------------------------------------------
    logic [ACC_W-1:0] ftw_q;
    logic [ACC_W-1:0] acc_q;
    logic [15:0]      phase_word_q;
    logic [9:0]       fsc_out_q;

    // holdover and switchover keep the last word; history lives upstream
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ftw_q <= '0;
        end else if (mode_i == DPL_FREE_RUN) begin
            ftw_q <= free_ftw_q;
        end else if (mode_i == DPL_CLOSED) begin
            ftw_q <= free_ftw_q + lp2_q;
        end
    end

    // modulo 2^48 wrap keeps the excess by plain truncation
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_q + ftw_q;
        end
    end

    // phase word and converter current leave from flops
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            phase_word_q <= '0;
            fsc_out_q    <= '0;
        end else begin
            phase_word_q <= acc_q[47:32] + phase_ofs_q;
            fsc_out_q    <= fsc_q[9:0];
        end
    end

    assign phase_word_o         = phase_word_q;
    assign full_scale_current_o = fsc_out_q;

    // ------------------------------------------------------------
    // lock detectors
    // ------------------------------------------------------------
    logic signed [LVL_W-1:0] lvl_q  [NUM_DET];
    logic                    lock_q [NUM_DET];
    logic                    vld_w  [NUM_DET];
    logic [ERR_W-1:0]        err_w  [NUM_DET];
    logic [ERR_W-1:0]        mag_w  [NUM_DET];
    logic                    pass_w [NUM_DET];

    assign vld_w[0] = phase_err_vld_i;
    assign err_w[0] = phase_err_i;
    assign vld_w[1] = period_dev_vld_i;
    assign err_w[1] = period_dev_i;

    generate
        for (genvar g = 0; g < NUM_DET; g++) begin : g_det
            logic signed [LVL_W-1:0] lvl_d;
            logic signed [LVL_W-1:0] lvl_add;
            logic signed [LVL_W-1:0] lvl_sub;

            // sign is dropped; only distance from zero counts
            always_comb begin
                mag_w[g]  = err_w[g][ERR_W-1] ? (~err_w[g] + 32'h1) : err_w[g];
                pass_w[g] = mag_w[g] <= {8'h00, det_cfg_q[g].thresh};
                lvl_add   = lvl_q[g] + $signed({6'h00, det_cfg_q[g].fill});
                lvl_sub   = lvl_q[g] - $signed({6'h00, det_cfg_q[g].drain});
                if (pass_w[g]) begin
                    lvl_d = (lvl_add > LVL_FULL) ? LVL_FULL : lvl_add;
                end else begin
                    lvl_d = (lvl_sub < LVL_EMPTY) ? LVL_EMPTY : lvl_sub;
                end
            end

            // free-run and holdover empty the tub so relock needs fresh evidence
            always_ff @(posedge sys_clk_i) begin
                if (reset_i) begin
                    lvl_q[g]  <= LVL_EMPTY;
                    lock_q[g] <= 1'b0;
                end else if (mode_i == DPL_FREE_RUN || mode_i == DPL_HOLDOVER) begin
                    lvl_q[g]  <= LVL_EMPTY;
                    lock_q[g] <= 1'b0;
                end else if (mode_i == DPL_CLOSED && vld_w[g]) begin
                    lvl_q[g] <= lvl_d;
                    if (lvl_d > LVL_HIGH) begin
                        lock_q[g] <= 1'b1;
                    end else if (lvl_d < LVL_LOW) begin
                        lock_q[g] <= 1'b0;
                    end
                end
            end

            a_level_range: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                lvl_q[g] >= LVL_EMPTY && lvl_q[g] <= LVL_FULL)
                else $error("detector level out of range");
            a_lock_marks: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                (lvl_q[g] > LVL_HIGH |-> lock_q[g]) and (lvl_q[g] < LVL_LOW |-> !lock_q[g]))
                else $error("lock flag disagrees with level");
            a_fill_step: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                (mode_i == DPL_CLOSED && vld_w[g] && pass_w[g] && lvl_add <= LVL_FULL)
                |=> lvl_q[g] == $past(lvl_q[g]) + $signed({6'h00, $past(det_cfg_q[g].fill)}))
                else $error("fill amount not applied");
            a_drain_step: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                (mode_i == DPL_CLOSED && vld_w[g] && !pass_w[g] && lvl_sub >= LVL_EMPTY)
                |=> lvl_q[g] == $past(lvl_q[g]) - $signed({6'h00, $past(det_cfg_q[g].drain)}))
                else $error("drain amount not applied");
            a_open_unlock: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                (mode_i == DPL_FREE_RUN || mode_i == DPL_HOLDOVER) |=> !lock_q[g])
                else $error("lock shown in open loop");
            a_switch_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
                mode_i == DPL_SWITCH |=> $stable(lock_q[g]) && $stable(lvl_q[g]))
                else $error("switchover changed detector");
            c_reach_lock: cover property (@(posedge sys_clk_i) disable iff (reset_i)
                !lock_q[g] ##1 lock_q[g]);
        end
    endgenerate

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    logic ph_lock_q;
    logic fr_lock_q;
    logic irq_q;

    // delayed copies give the edge events
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ph_lock_q <= 1'b0;
            fr_lock_q <= 1'b0;
        end else begin
            ph_lock_q <= lock_q[0];
            fr_lock_q <= lock_q[1];
        end
    end

    always_comb begin
        irq_evt              = '0;
        irq_evt[IRQ_PH_LOCK] = lock_q[0] && !ph_lock_q;
        irq_evt[IRQ_PH_LOST] = !lock_q[0] && ph_lock_q;
        irq_evt[IRQ_FR_LOCK] = lock_q[1] && !fr_lock_q;
        irq_evt[IRQ_FR_LOST] = !lock_q[1] && fr_lock_q;
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_stat_q <= '0;
        end else if (wr_i && addr_i == OFS_IRQ_STATUS) begin
            irq_stat_q <= (irq_stat_q & ~wdata_i[3:0]) | irq_evt;
        end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign irq_o        = irq_q;
    assign phase_lock_o = ph_lock_q;
    assign freq_lock_o  = fr_lock_q;

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] rdata_q;

    // unmapped addresses read as zero
    always_comb begin
        rd_mux = '0;
        case (addr_i)
            OFS_FULL_SCALE: rd_mux = fsc_q;
            OFS_PHASE_OFS:  rd_mux = phase_ofs_q;
            OFS_FREE_FTW0:  rd_mux = free_ftw_q[15:0];
            OFS_FREE_FTW1:  rd_mux = free_ftw_q[31:16];
            OFS_FREE_FTW2:  rd_mux = free_ftw_q[47:32];
            OFS_PH_THRESH:  rd_mux = det_cfg_q[0].thresh[15:0];
            OFS_PH_BUCKET:  rd_mux = {det_cfg_q[0].drain, det_cfg_q[0].fill};
            OFS_FR_THR_LO:  rd_mux = det_cfg_q[1].thresh[15:0];
            OFS_FR_THR_HI:  rd_mux = {8'h00, det_cfg_q[1].thresh[23:16]};
            OFS_FR_BUCKET:  rd_mux = {det_cfg_q[1].drain, det_cfg_q[1].fill};
            OFS_STATUS:     rd_mux = {12'h000, mode_i, lock_q[1], lock_q[0]};
            OFS_IRQ_STATUS: rd_mux = {12'h000, irq_stat_q};
            OFS_IRQ_MASK:   rd_mux = {12'h000, irq_mask_q};
            default: begin
                for (int k = 0; k < 4; k++) begin
                    if (addr_i == OFS_COEF_BASE + 12'(2 * k)) begin
                        rd_mux = coef_q[k].frac;
                    end
                    if (addr_i == OFS_COEF_BASE + 12'(2 * k + 1)) begin
                        rd_mux = {5'h00, coef_q[k].pos_b, coef_q[k].pos_a, coef_q[k].neg_exp};
                    end
                end
            end
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rd_i ? rd_mux : '0;
        end
    end

    assign rdata_o = rdata_q;

    // ------------------------------------------------------------
    // checks on the datapath and bus
    // ------------------------------------------------------------
    a_accum_step: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !$past(reset_i) |-> acc_q == $past(acc_q) + $past(ftw_q))
        else $error("accumulator did not add step word");
    a_phase_ofs: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !$past(reset_i) |-> phase_word_o == $past(acc_q[47:32]) + $past(phase_ofs_q))
        else $error("phase offset not applied");
    a_fsc_out: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (wr_i && addr_i == OFS_FULL_SCALE) |=> ##1 full_scale_current_o == $past(wdata_i[9:0], 2))
        else $error("full-scale word not delivered");
    a_ftw_free: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        mode_i == DPL_FREE_RUN |=> ftw_q == $past(free_ftw_q))
        else $error("free-run word not selected");
    a_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !$past(rd_i) |-> rdata_o == '0)
        else $error("read data outside its slot");
    a_irq_level: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        |(irq_stat_q & irq_mask_q) |=> irq_o)
        else $error("unmasked status without interrupt");

    c_wrap: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        acc_q < $past(acc_q));
    c_switch_locked: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        lock_q[0] && mode_i == DPL_SWITCH ##1 mode_i == DPL_CLOSED);
    c_irq: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        $rose(irq_o));

endmodule

// ==== hw/dpl_pkg.sv ====
// package for the dpll lock detector and synthesizer back end
// assumes one 100 MHz sample clock shared with upstream loop logic
package dpl_pkg;

    // ------------------------------------------------------------
    // bus and data widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int ERR_W  = 32;                 // signed picosecond samples
    localparam int ACC_W  = 48;
    localparam int LVL_W  = 14;                 // holds -2048..+2048 plus headroom
    localparam int NUM_DET = 2;                 // 0: phase detector, 1: frequency detector

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_FULL_SCALE  = 12'h213;
    localparam logic [11:0] OFS_PHASE_OFS   = 12'h30D;
    localparam logic [11:0] OFS_FREE_FTW0   = 12'h300;  // bits 15:0 of free-run word
    localparam logic [11:0] OFS_FREE_FTW1   = 12'h301;
    localparam logic [11:0] OFS_FREE_FTW2   = 12'h302;
    localparam logic [11:0] OFS_COEF_BASE   = 12'h320;  // frac at base+2k, exps at base+2k+1
    localparam logic [11:0] OFS_PH_THRESH   = 12'h328;
    localparam logic [11:0] OFS_PH_BUCKET   = 12'h329;  // [7:0] fill, [15:8] drain
    localparam logic [11:0] OFS_FR_THR_LO   = 12'h32A;
    localparam logic [11:0] OFS_FR_THR_HI   = 12'h32B;  // [7:0] = threshold bits 23:16
    localparam logic [11:0] OFS_FR_BUCKET   = 12'h32C;
    localparam logic [11:0] OFS_STATUS      = 12'h330;
    localparam logic [11:0] OFS_IRQ_STATUS  = 12'h331;
    localparam logic [11:0] OFS_IRQ_MASK    = 12'h332;

    // ------------------------------------------------------------
    // reset values and detector marks
    // ------------------------------------------------------------
    localparam logic [15:0]        RST_REG    = 16'h0000;
    localparam logic signed [13:0] LVL_EMPTY  = -14'sd2048;
    localparam logic signed [13:0] LVL_FULL   = 14'sd2048;
    localparam logic signed [13:0] LVL_LOW    = -14'sd1024;
    localparam logic signed [13:0] LVL_HIGH   = 14'sd1024;
    localparam int                 FRAC_BITS  = 16;

    // irq status bit positions
    localparam int IRQ_PH_LOCK = 0;
    localparam int IRQ_PH_LOST = 1;
    localparam int IRQ_FR_LOCK = 2;
    localparam int IRQ_FR_LOST = 3;

    // loop mode from the loop control logic
    typedef enum logic [1:0] {
        DPL_CLOSED   = 2'h0,
        DPL_FREE_RUN = 2'h1,
        DPL_HOLDOVER = 2'h2,
        DPL_SWITCH   = 2'h3
    } dpl_mode_t;

    // one loop-filter coefficient
    typedef struct packed {
        logic [15:0] frac;      // 0 .. just below one
        logic [4:0]  neg_exp;   // scale by 2^-x
        logic [2:0]  pos_a;     // alpha only: scale by 2^x
        logic [2:0]  pos_b;     // alpha only: second 2^x term
    } dpl_coef_t;

    // one detector's settings
    typedef struct packed {
        logic [23:0] thresh;
        logic [7:0]  fill;
        logic [7:0]  drain;
    } dpl_det_cfg_t;

endpackage
